// ==== hdl/fcdma_map.vh ====
// register map, field positions and encodings of the four-channel dma
`ifndef FCDMA_MAP_VH
`define FCDMA_MAP_VH

// ----------------------------------------
// register index within a channel window
// ----------------------------------------
`define FC_R_SAR 3'h0
`define FC_R_DAR 3'h1
`define FC_R_BCR 3'h2
`define FC_R_CTL 3'h3
`define FC_R_STA 3'h4
`define FC_R_LAST 3'h4

// ----------------------------------------
// channel_control fields
// ----------------------------------------
`define FC_C_INT 0
`define FC_C_EXT 1
`define FC_C_CS 2
`define FC_C_AA 3
`define FC_C_SOURCE_INCREMENT 4
`define FC_C_DEST_INCREMENT 5
`define FC_C_SSZ 6
`define FC_C_DSZ 8
`define FC_C_BWC 10
`define FC_C_START 13
`define FC_CTL_W 14

// ----------------------------------------
// channel_status fields
// ----------------------------------------
`define FC_S_DONE 0
`define FC_S_BSY 1
`define FC_S_REQ 2
`define FC_S_BED 4
`define FC_S_BES 5
`define FC_S_CE 6

// ----------------------------------------
// width codes and bandwidth block size
// ----------------------------------------
`define FC_W_LONG 2'h0
`define FC_W_BYTE 2'h1
`define FC_W_WORD 2'h2
`define FC_W_LINE 2'h3
`define FC_BWC_UNLIM 3'h0
`define FC_BLK_SH 6
`define FC_BCR_W 24

`endif

// ==== hdl/fcdma_top.v ====
// four-channel dual-address dma engine with apb register access
// ----------------------------------------
// How it works
// - start bit or external line requests
// - external line only when enabled
// - cycle steal: one transfer per request
// - continuous runs to zero, boundary, done
// - unlimited code keeps bus request
// - drop request at boundary, re-request
// - seven block sizes from bandwidth code
// - skipped boundary keeps request asserted
// - read phase, source increment, multi reads
// - write phase, decrement, done or repeat
// - pending flag while waiting unselected
// - bus errors set flags and halt
// - increments 1,2,4,8,16 or held
// - internal starts at once, external waits
// - control writes act at once, abort
// - fixed ascending channel priority
// - unlimited outranks only next lower
// - auto align picks larger side
// - aligned size from address, count
// - other side largest legal access
// - interrupt at end, done clears all
// - misaligned setup sets config error
// - zero count at start is error
// - start bit clears at first access
// - transfer moves larger width bytes, aligned size when auto aligned
// ----------------------------------------
`timescale 1ns/1ns
`include "fcdma_map.vh"

module fcdma_top (
    input wire clk_sys,
    input wire rst_b,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [3:0] dma_request_in,
    output wire [3:0] dma_irq,
    output wire bus_req,
    input wire bus_grant,
    output wire bus_valid,
    output wire bus_write,
    output wire [31:0] bus_addr,
    output wire [4:0] bus_size,
    output wire [127:0] bus_wdata,
    input wire [127:0] bus_rdata,
    input wire bus_done,
    input wire bus_err
);

localparam S_IDLE = 3'h0;
localparam S_CHK = 3'h1;
localparam S_RD = 3'h2;
localparam S_WR = 3'h3;
localparam S_GAP = 3'h4;

// ----------------------------------------
// helpers
// ----------------------------------------
function [4:0] wbytes;
    input [1:0] code;
    begin
        case (code)
            `FC_W_BYTE: wbytes = 5'h01;
            `FC_W_WORD: wbytes = 5'h02;
            `FC_W_LINE: wbytes = 5'h10;
            default: wbytes = 5'h04;
        endcase
    end
endfunction

// largest power of two not above cap, aligned to a and not above lim
function [4:0] fit;
    input [3:0] a;
    input [4:0] cap;
    input [23:0] lim;
    integer k;
    reg [4:0] s;
    begin
        s = cap;
        for (k = 0; k < 4; k = k + 1) begin
            if (s > 5'h01 && ((a & (s[3:0] - 4'h1)) != 4'h0 || {19'h0, s} > lim)) begin
                s = s >> 1;
            end
        end
        fit = s;
    end
endfunction

// ----------------------------------------
// state
// ----------------------------------------
reg [31:0] sar_r [0:3];
reg [31:0] dar_r [0:3];
reg [23:0] bcr_r [0:3];
reg [13:0] ctl_r [0:3];
reg [3:0] done_r;
reg [3:0] ce_r;
reg [3:0] bes_r;
reg [3:0] bed_r;
reg [3:0] cont_r;
reg [2:0] st_r;
reg [1:0] ch_r;
reg [4:0] rsz_r;
reg [4:0] wsz_r;
reg [4:0] tsz_r;
reg [4:0] cnt_r;
reg [127:0] hold_r;
integer i, j, n;

// ----------------------------------------
// apb decode
// ----------------------------------------
wire [1:0] a_ch = paddr[6:5];
wire [2:0] a_ix = paddr[4:2];
wire a_bad = (paddr[11:7] != 5'h00) || (a_ix > `FC_R_LAST) || (paddr[1:0] != 2'h0);
wire wen = psel & penable & pwrite & ~a_bad;
assign pready = 1'b1;
assign pslverr = psel & penable & a_bad;

reg [3:0] dclr;
reg [3:0] want;
reg [3:0] z;
reg [3:0] stat_req;
always @* begin
    for (i = 0; i < 4; i = i + 1) begin
        // done write clears status and stops
        dclr[i] = wen && a_ch == i[1:0] && a_ix == `FC_R_STA && pwdata[`FC_S_DONE];
        // external channel waits for its line
        want[i] = (ctl_r[i][`FC_C_START] | (ctl_r[i][`FC_C_EXT] & dma_request_in[i])
                   | cont_r[i]) & ~done_r[i];
        z[i] = ctl_r[i][`FC_C_BWC +: 3] == `FC_BWC_UNLIM;
        // pending while requested but not selected
        stat_req[i] = want[i] & ~(st_r != S_IDLE && ch_r == i[1:0]);
    end
end

always @* begin
    prdata = 32'h0;
    if (psel && !pwrite && !a_bad) begin
        case (a_ix)
            `FC_R_SAR: prdata = sar_r[a_ch];
            `FC_R_DAR: prdata = dar_r[a_ch];
            `FC_R_BCR: prdata = {8'h0, bcr_r[a_ch]};
            `FC_R_CTL: prdata = {18'h0, ctl_r[a_ch]};
            default: prdata = {25'h0, ce_r[a_ch], bes_r[a_ch], bed_r[a_ch], 1'b0,
                               stat_req[a_ch], want[a_ch] | (st_r != S_IDLE && ch_r == a_ch),
                               done_r[a_ch]};
        endcase
    end
end

assign dma_irq[0] = done_r[0] & ctl_r[0][`FC_C_INT];
assign dma_irq[1] = done_r[1] & ctl_r[1][`FC_C_INT];
assign dma_irq[2] = done_r[2] & ctl_r[2][`FC_C_INT];
assign dma_irq[3] = done_r[3] & ctl_r[3][`FC_C_INT];

// ----------------------------------------
// arbitration
// ----------------------------------------
// ascending order by default
// unlimited channel swaps with next lower only
// the swap pairs can never overlap, so one pass is enough
reg [7:0] ord;
reg [1:0] pk;
reg pk_v;
reg [1:0] tmp;
always @* begin
    ord = 8'he4;
    tmp = 2'h0;
    for (j = 1; j < 4; j = j + 1) begin
        if (z[j] && !z[j - 1]) begin
            tmp = ord[2 * j +: 2];
            ord[2 * j +: 2] = ord[2 * j - 2 +: 2];
            ord[2 * j - 2 +: 2] = tmp;
        end
    end
    pk = 2'h0;
    pk_v = 1'b0;
    for (j = 3; j >= 0; j = j - 1) begin
        if (want[ord[2 * j +: 2]]) begin
            pk = ord[2 * j +: 2];
            pk_v = 1'b1;
        end
    end
end

// ----------------------------------------
// transfer sizing for the selected channel
// ----------------------------------------
wire [13:0] cc = ctl_r[ch_r];
wire [31:0] sa = sar_r[ch_r];
wire [31:0] da = dar_r[ch_r];
wire [23:0] bc = bcr_r[ch_r];
wire [4:0] rc = wbytes(cc[`FC_C_SSZ +: 2]);
wire [4:0] wc = wbytes(cc[`FC_C_DSZ +: 2]);
wire aa = cc[`FC_C_AA];
// source aligned when its width is not smaller
wire src_al = rc >= wc;
// aligned size limited by address and remaining count
wire [4:0] al_sz = src_al ? fit(sa[3:0], rc, bc) : fit(da[3:0], wc, bc);
// other side takes the largest legal access
wire [4:0] ot_sz = src_al ? fit(da[3:0], wc, {19'h0, al_sz}) : fit(sa[3:0], rc, {19'h0, al_sz});
// transfer moves the larger configured width
wire [4:0] t_nrm = src_al ? rc : wc;
wire [4:0] rsz_n = aa ? (src_al ? al_sz : ot_sz) : rc;
wire [4:0] wsz_n = aa ? (src_al ? ot_sz : al_sz) : wc;
wire [4:0] tsz_n = aa ? al_sz : t_nrm;
// alignment checks when not auto aligned
wire mis = !aa && (((sa[4:0] & (rc - 5'h01)) != 5'h00) || ((da[4:0] & (wc - 5'h01)) != 5'h00)
           || ((bc[4:0] & (t_nrm - 5'h01)) != 5'h00));
// increment when counting, aligned side always
wire s_inc = cc[`FC_C_SOURCE_INCREMENT] | (aa & src_al);
wire d_inc = cc[`FC_C_DEST_INCREMENT] | (aa & ~src_al);

// seven block sizes, 1 << (code + shift) bytes
wire [2:0] bandwidth_limit = cc[`FC_C_BWC +: 3];
wire [23:0] blk_m = (24'h1 << ({1'b0, bandwidth_limit} + 4'd`FC_BLK_SH)) - 24'h1;
wire [23:0] nb = bc - {19'h0, tsz_r};
wire r_last = (cnt_r + rsz_r) >= tsz_r;
wire w_last = (cnt_r + wsz_r) >= tsz_r;
// only an exact landing on a boundary drops the request
wire land = bandwidth_limit != `FC_BWC_UNLIM && nb != 24'h0 && (nb & blk_m) == 24'h0 && !cc[`FC_C_CS];

// ----------------------------------------
// internal bus master
// ----------------------------------------
// request drops during the last write before a boundary
// otherwise held until the count runs out, or in cycle steal until each transfer ends
wire drop = st_r == S_WR && w_last && land;
// only the selected channel reaches the bus
assign bus_req = (st_r == S_CHK || st_r == S_RD || st_r == S_WR) && !drop;
assign bus_valid = (st_r == S_RD || st_r == S_WR) && bus_grant;
assign bus_write = st_r == S_WR;
assign bus_addr = (st_r == S_WR) ? da : sa;
assign bus_size = (st_r == S_WR) ? wsz_r : rsz_r;
assign bus_wdata = hold_r >> {cnt_r, 3'h0};
wire beat = bus_valid & bus_done;

// ----------------------------------------
// registers and engine
// ----------------------------------------
always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
        for (n = 0; n < 4; n = n + 1) begin
            sar_r[n] <= 32'h0;
            dar_r[n] <= 32'h0;
            bcr_r[n] <= 24'h0;
            ctl_r[n] <= 14'h0;
        end
        done_r <= 4'h0;
        ce_r <= 4'h0;
        bes_r <= 4'h0;
        bed_r <= 4'h0;
        cont_r <= 4'h0;
        st_r <= S_IDLE;
        ch_r <= 2'h0;
        rsz_r <= 5'h0;
        wsz_r <= 5'h0;
        tsz_r <= 5'h0;
        cnt_r <= 5'h0;
        hold_r <= 128'h0;
    end else begin
        // software side first, so hardware sets below win
        if (wen) begin
            case (a_ix)
                `FC_R_SAR: sar_r[a_ch] <= pwdata;
                `FC_R_DAR: dar_r[a_ch] <= pwdata;
                `FC_R_BCR: bcr_r[a_ch] <= pwdata[23:0];
                `FC_R_CTL: ctl_r[a_ch] <= pwdata[13:0];
                default: ;
            endcase
        end
        for (n = 0; n < 4; n = n + 1) begin
            if (dclr[n]) begin
                done_r[n] <= 1'b0;
                ce_r[n] <= 1'b0;
                bes_r[n] <= 1'b0;
                bed_r[n] <= 1'b0;
                cont_r[n] <= 1'b0;
            end
        end
        case (st_r)
            S_IDLE: begin
                if (pk_v) begin
                    ch_r <= pk;
                    st_r <= S_CHK;
                end
            end
            S_CHK: begin
                if (!want[ch_r]) begin
                    st_r <= S_IDLE;
                // zero count with a start is an error
                end else if (bc == 24'h0 || mis) begin
                    ce_r[ch_r] <= 1'b1;
                    done_r[ch_r] <= 1'b1;
                    cont_r[ch_r] <= 1'b0;
                    ctl_r[ch_r][`FC_C_START] <= 1'b0;
                    st_r <= S_IDLE;
                end else begin
                    rsz_r <= rsz_n;
                    wsz_r <= wsz_n;
                    tsz_r <= tsz_n;
                    cnt_r <= 5'h0;
                    hold_r <= 128'h0;
                    // start clears as the access begins
                    ctl_r[ch_r][`FC_C_START] <= 1'b0;
                    // continuous mode keeps its own request
                    cont_r[ch_r] <= ~cc[`FC_C_CS];
                    st_r <= S_RD;
                end
            end
            S_RD: begin
                if (beat) begin
                    if (bus_err) begin
                        bes_r[ch_r] <= 1'b1;
                        done_r[ch_r] <= 1'b1;
                        cont_r[ch_r] <= 1'b0;
                        st_r <= S_IDLE;
                    end else begin
                        // gather reads until a full transfer is held
                        hold_r <= hold_r | ((bus_rdata & ~({128{1'b1}} << {rsz_r, 3'h0}))
                                  << {cnt_r, 3'h0});
                        if (s_inc) begin
                            sar_r[ch_r] <= sa + {27'h0, rsz_r};
                        end
                        cnt_r <= r_last ? 5'h0 : cnt_r + rsz_r;
                        if (r_last) begin
                            st_r <= S_WR;
                        end
                    end
                end
            end
            S_WR: begin
                if (beat) begin
                    if (bus_err) begin
                        // failed write loses the held data
                        bed_r[ch_r] <= 1'b1;
                        done_r[ch_r] <= 1'b1;
                        cont_r[ch_r] <= 1'b0;
                        hold_r <= 128'h0;
                        st_r <= S_IDLE;
                    end else begin
                        if (d_inc) begin
                            dar_r[ch_r] <= da + {27'h0, wsz_r};
                        end
                        cnt_r <= w_last ? 5'h0 : cnt_r + wsz_r;
                        if (w_last) begin
                            bcr_r[ch_r] <= nb;
                            if (nb == 24'h0) begin
                                done_r[ch_r] <= 1'b1;
                                cont_r[ch_r] <= 1'b0;
                                st_r <= S_IDLE;
                            end else if (cc[`FC_C_CS]) begin
                                st_r <= S_IDLE;
                            end else if (land) begin
                                st_r <= S_GAP;
                            end else begin
                                st_r <= S_CHK;
                            end
                        end
                    end
                end
            end
            S_GAP: begin
                // one idle cycle then arbitrate again
                st_r <= S_IDLE;
            end
            default: st_r <= S_IDLE;
        endcase
        // aborting the running channel ends its sequence
        if (dclr[ch_r] && st_r != S_IDLE) begin
            st_r <= S_IDLE;
            cont_r[ch_r] <= 1'b0;
        end
    end
end

endmodule

// ==== test/fcdma_top_assertions.sv ====
// port checks for the four-channel dma engine
`timescale 1ns/1ns
module fcdma_chk (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic [3:0] dma_irq,
    input wire logic bus_req,
    input wire logic bus_grant,
    input wire logic bus_valid,
    input wire logic bus_write,
    input wire logic [31:0] bus_addr,
    input wire logic [4:0] bus_size,
    input wire logic bus_done,
    input wire logic bus_err
);
default clocking cb @(posedge clk_sys);
endclocking
default disable iff (!rst_b);
sequence s_apb_acc;
    psel && penable;
endsequence
sequence s_beat_wait;
    bus_valid && !bus_done;
endsequence
sequence s_beat_end;
    bus_valid && bus_done;
endsequence
a_one_owner: assert property ($rose(bus_valid) |-> $past(bus_req))
    else $error("access started without request");
a_access_held: assert property (s_beat_wait ##1 bus_valid |->
    $stable({bus_addr, bus_size, bus_write}))
    else $error("access changed before done");
a_size_legal: assert property (bus_valid |->
    bus_size inside {5'h01, 5'h02, 5'h04, 5'h10})
    else $error("illegal access size");
a_halt_on_err: assert property (s_beat_end ##0 bus_err |=> !bus_valid)
    else $error("access right after bus error");
a_write_last: assert property (s_beat_end ##0 bus_write |=> !(bus_valid && !bus_write))
    else $error("read straight after write");
a_req_gap: assert property (s_beat_end ##0 !bus_req |=> !bus_req)
    else $error("request gap too short");
a_done_clears_irq: assert property (s_apb_acc ##0 (pwrite && paddr[11:7] == 5'h00 &&
    paddr[4:0] == 5'h10 && pwdata[0]) |=> !dma_irq[$past(paddr[6:5])])
    else $error("interrupt kept after clear");
a_unmapped_err: assert property (s_apb_acc ##0 (paddr[1:0] != 2'h0) |->
    pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access accepted");
endmodule

bind fcdma_top fcdma_chk u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pslverr(pslverr), .dma_irq(dma_irq), .bus_req(bus_req), .bus_grant(bus_grant),
    .bus_valid(bus_valid), .bus_write(bus_write), .bus_addr(bus_addr),
    .bus_size(bus_size), .bus_done(bus_done), .bus_err(bus_err));

// ==== test/fcdma_mem.sv ====
// internal bus memory and grant model facing the dma engine
`timescale 1ns/1ns
module fcdma_mem (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic bus_req,
    output logic bus_grant,
    input wire logic bus_valid,
    input wire logic bus_write,
    input wire logic [31:0] bus_addr,
    input wire logic [4:0] bus_size,
    input wire logic [127:0] bus_wdata,
    output logic [127:0] bus_rdata,
    output logic bus_done,
    output logic bus_err,
    input wire logic [3:0] lat,
    input wire logic err_rd,
    input wire logic err_wr
);
logic [7:0] mem [0:255];
logic [3:0] cnt_r;
integer i;
always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
        bus_grant <= 1'b0;
        bus_done <= 1'b0;
        bus_err <= 1'b0;
        bus_rdata <= 128'h0;
        cnt_r <= 4'h0;
    end else begin
        // grant kept until the beat in flight ends
        bus_grant <= bus_req || (bus_valid && !bus_done);
        bus_done <= 1'b0;
        bus_err <= 1'b0;
        // idle read data toggles so a stale beat never matches by luck
        bus_rdata <= ~bus_rdata;
        cnt_r <= (bus_valid && !bus_done) ? cnt_r + 4'h1 : 4'h0;
        if (bus_valid && !bus_done && cnt_r >= lat) begin
            bus_done <= 1'b1;
            // errors only on the bench's command
            bus_err <= bus_write ? err_wr : err_rd;
            for (i = 0; i < 16; i = i + 1)
                bus_rdata[i*8 +: 8] <= mem[(bus_addr + i) % 256];
        end
        if (bus_valid && bus_done && bus_write && !bus_err)
            for (i = 0; i < 16; i = i + 1)
                if (i < bus_size)
                    mem[(bus_addr + i) % 256] <= bus_wdata[i*8 +: 8];
    end
end
endmodule

// ==== test/fcdma_test.sv ====
// bench for the four-channel dma engine
`timescale 1ns/1ns
module fcdma_test;
reg clk_sys = 1'b0;
reg rst_b = 1'b0;
reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err_rd = 1'b0, err_wr = 1'b0, req_q = 1'b0;
reg [11:0] paddr = 12'h000;
reg [31:0] pwdata = 32'h0;
reg [3:0] dma_request_in = 4'h0;
reg [3:0] lat = 4'h1;
reg [31:0] rdv;
reg sev;
integer fail_count = 0, n_compared = 0, rises = 0, beats = 0;
integer i, k, m;
wire [31:0] prdata, bus_addr;
wire [127:0] bus_wdata, bus_rdata;
wire [4:0] bus_size;
wire [3:0] dma_irq;
wire pready, pslverr, bus_req, bus_grant, bus_valid, bus_write, bus_done, bus_err;
fcdma_top dut (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dma_request_in(dma_request_in), .dma_irq(dma_irq), .bus_req(bus_req),
    .bus_grant(bus_grant), .bus_valid(bus_valid), .bus_write(bus_write), .bus_addr(bus_addr),
    .bus_size(bus_size), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_done(bus_done),
    .bus_err(bus_err));
fcdma_mem u_mem (.clk_sys(clk_sys), .rst_b(rst_b), .bus_req(bus_req), .bus_grant(bus_grant),
    .bus_valid(bus_valid), .bus_write(bus_write), .bus_addr(bus_addr), .bus_size(bus_size),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_done(bus_done), .bus_err(bus_err),
    .lat(lat), .err_rd(err_rd), .err_wr(err_wr));
always #50 clk_sys = ~clk_sys;
always @(posedge clk_sys) begin
    req_q <= bus_req;
    if (bus_req && !req_q)
        rises <= rises + 1;
    if (bus_valid && bus_done)
        beats <= beats + 1;
end
function [7:0] pat(input [7:0] a);
    pat = a ^ 8'h5a;
endfunction
task chk(input [31:0] seen, input [31:0] exp);
    begin
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    end
endtask
task test_done;
    begin
        $display("compared %0d mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    end
endtask
task hung;
    begin
        fail_count = fail_count + 1;
        $display("BAD %0t wait ran out", $time);
        test_done;
    end
endtask
task apb(input w, input [11:0] a, input [31:0] d);
    integer t;
    begin
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        t = 0;
        @(posedge clk_sys);
        while (pready !== 1'b1) begin
            t = t + 1;
            if (t > 20)
                hung;
            @(posedge clk_sys);
        end
        rdv = prdata;
        sev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    end
endtask
task wait_end(input [1:0] c);
    integer t;
    begin
        rdv = 0;
        for (t = 0; rdv[0] !== 1'b1 && rdv[6] !== 1'b1; t = t + 1) begin
            if (t > 400)
                hung;
            apb(0, {5'h0, c, 5'h10}, 0);
        end
    end
endtask
task setup(input [1:0] c, input [7:0] s, input [7:0] d, input [23:0] n, input [13:0] f);
    begin
        // done cleared and count loaded before start
        apb(1, {5'h0, c, 5'h10}, 1);
        apb(1, {5'h0, c, 5'h00}, s);
        apb(1, {5'h0, c, 5'h04}, d);
        apb(1, {5'h0, c, 5'h08}, n);
        apb(1, {5'h0, c, 5'h0c}, f);
    end
endtask
task t_copy;
    begin
        setup(0, 8'h10, 8'h80, 8, 14'h2031);
        wait_end(0);
        chk(rdv[6:0], 7'h01);
        for (i = 0; i < 8; i = i + 1)
            chk(u_mem.mem[8'h80 + i], pat(8'h10 + i[7:0]));
        chk(dma_irq[0], 1);
        apb(0, 12'h000, 0);
        chk(rdv, 32'h18);
        apb(0, 12'h004, 0);
        chk(rdv, 32'h88);
        apb(0, 12'h00c, 0);
        chk(rdv[13], 0);
        apb(1, 12'h010, 1);
        chk(dma_irq[0], 0);
        apb(0, 12'h016, 0);
        chk(sev, 1);
        $display("copy finished");
    end
endtask
task t_align;
    begin
        // source side aligned: its address counts although source_increment is off
        m = beats;
        setup(1, 8'h71, 8'ha1, 7, 14'h2128);
        wait_end(1);
        chk(rdv[6:0], 7'h01);
        for (i = 0; i < 7; i = i + 1)
            chk(u_mem.mem[8'ha1 + i], pat(8'h71 + i[7:0]));
        // reads of 1, 2 and 4 bytes, each followed by its byte writes, seven writes in all
        chk(beats - m, 10);
        apb(0, 12'h020, 0);
        chk(rdv, 32'h78);
        apb(0, 12'h024, 0);
        chk(rdv, 32'ha8);
        $display("auto align finished");
    end
endtask
task t_fault;
    begin
        for (k = 0; k < 4; k = k + 1) begin
            err_rd <= (k == 0);
            err_wr <= (k == 1);
            setup(3, (k == 3) ? 8'h31 : 8'h30, 8'hb0, (k == 2) ? 0 : 4, 14'h2031);
            wait_end(3);
            if (k < 2) begin
                chk(rdv[6:0], (k == 0) ? 7'h21 : 7'h11);
                chk(dma_irq[3], 1);
            end else
                chk(rdv[6], 1);
            chk(u_mem.mem[8'hb0], pat(8'hb0));
        end
        err_rd <= 1'b0;
        err_wr <= 1'b0;
        $display("faults finished");
    end
endtask
task t_ext;
    begin
        lat <= 4'h4;
        setup(2, 8'h40, 8'hc0, 4, 14'h0164);
        dma_request_in <= 4'h4;
        repeat (30) @(posedge clk_sys);
        apb(0, 12'h048, 0);
        chk(rdv, 4);
        // line enabled by a control write while the line is held
        apb(1, 12'h04c, 32'h166);
        wait_end(2);
        dma_request_in <= 4'h0;
        for (i = 0; i < 4; i = i + 1)
            chk(u_mem.mem[8'hc0 + i], pat(8'h40));
        apb(0, 12'h040, 0);
        chk(rdv, 32'h40);
        lat <= 4'h1;
        $display("external finished");
    end
endtask
task t_bw;
    begin
        for (k = 0; k < 2; k = k + 1) begin
            m = rises;
            setup(0, 8'he0, 8'hf0, 256, {1'b1, k[2:0], 10'h000});
            wait_end(0);
            // one request when unlimited, a second after the 128-byte block
            chk(rises - m, k + 1);
        end
        $display("bandwidth finished");
    end
endtask
task t_prio;
    begin
        for (k = 0; k < 2; k = k + 1) begin
            setup(0, 8'h50, 8'h58, 2, 14'h0572);
            setup(1, 8'h60, 8'h68, 2, {1'b0, (k == 0) ? 3'h1 : 3'h0, 10'h172});
            dma_request_in <= 4'h3;
            for (i = 0; bus_valid !== 1'b1 && i < 50; i = i + 1)
                @(posedge clk_sys);
            if (bus_valid !== 1'b1)
                hung;
            chk(bus_addr, (k == 0) ? 32'h50 : 32'h60);
            // the losing channel waits with its request shown pending
            apb(0, (k == 0) ? 12'h030 : 12'h010, 0);
            chk(rdv[2], 1);
            wait_end(0);
            wait_end(1);
            dma_request_in <= 4'h0;
        end
        $display("priority finished");
    end
endtask
initial begin
    for (i = 0; i < 256; i = i + 1)
        u_mem.mem[i] = pat(i[7:0]);
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    t_copy;
    t_align;
    t_fault;
    t_ext;
    t_bw;
    t_prio;
    test_done;
end
endmodule
